// ---- pwc_timer.v ----
// pulse width capture timer: 16-bit up counter, four capture inputs, shared overflow flag
// assumes capture pins are asynchronous; count clock is a one-cycle enable from elsewhere
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`include "pwc_defs.vh"

// Overview of operation
// - mode 110 counts up once enable set
// - pulse mode edge captures, clears, requests irq
// - at FFFFH wrap next tick, overflow irq
// - overflow flag set on wrap, sticky
// - bit-clear bit0=1 or option write bit0=0 clears
// - one overflow flag for all channels
// - flag only records a wrap happened
// - counter read returns live count
// - output and input control ignored, pulse mode
// - capture equals ticks since previous edge
// - mode 101 free running, no clear
// - free mode edge captures, counter continues
module pwc_timer #(
  parameter WIDTH = 16
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        count_tick_i,
  input  wire [3:0]  capture_input_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire [3:0]  capture_irq_o,
  output wire        overflow_irq_o,
  output wire        irq_o
);

  // control registers on lane 0; ctrl, edge, outctl and extctl are one byte each
  reg [7:0]       ctrl_q;
  reg [7:0]       edge_sel_q;
  reg [7:0]       outctl_q;
  reg [7:0]       extctl_q;
  reg [4:0]       irq_en_q;
  reg [4:0]       stat_q;
  reg [4:0]       stat_d;
  reg             ovf_q;
  reg             ovf_d;

  // counter and capture registers
  reg [WIDTH-1:0] cnt_q;
  reg [WIDTH-1:0] cnt_d;
  reg [WIDTH-1:0] cap_q [0:3];

  // three flops per pin; pin_last_q keeps the previous synced level
  reg [3:0]       pin_meta_q;
  reg [3:0]       pin_sync_q;
  reg [3:0]       pin_last_q;

  // one-clock event pulses toward the interrupt controller
  reg [3:0]       cap_irq_q;
  reg             ovf_irq_q;

  integer         j;

  // edge qualifier per channel; the no-edge setting masks an unused pin
  function edge_hit;
    input [1:0] sel;
    input       now;
    input       prev;
    begin
      case (sel)
        `PWC_EDGE_RISE: edge_hit = now & ~prev;
        `PWC_EDGE_FALL: edge_hit = ~now & prev;
        `PWC_EDGE_BOTH: edge_hit = now ^ prev;
        default:        edge_hit = 1'b0;
      endcase
    end
  endfunction

  // byte address of capture register for a channel number
  function [5:0] cap_adr;
    input [1:0] ch;
    begin
      case (ch)
        2'h0:    cap_adr = `PWC_ADR_CAP0;
        2'h1:    cap_adr = `PWC_ADR_CAP1;
        2'h2:    cap_adr = `PWC_ADR_CAP2;
        default: cap_adr = `PWC_ADR_CAP3;
      endcase
    end
  endfunction

  // write strobe for one register; only the byte lane 0 select is tested, even for 16-bit capture writes
  function wr_hit;
    input       wr;
    input [5:0] adr;
    input [3:0] sel;
    input [5:0] target;
    begin
      wr_hit = wr && sel[0] && (adr == target);
    end
  endfunction

  // mode decode
  wire [2:0] mode     = ctrl_q[`PWC_MODE_HI:`PWC_MODE_LO];
  wire       enable   = ctrl_q[`PWC_CTRL_CE];
  wire       is_pulse = (mode == `PWC_MODE_PULSE);
  wire       is_free  = (mode == `PWC_MODE_FREE);
  // other mode codes belong to functions left out here, so the counter stays at zero
  wire       running  = enable && (is_pulse || is_free);

  // a request is taken on the edge where ack is still low
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr  = bus_req && wb_we_i;
  wire bus_rd  = bus_req && !wb_we_i;

  // register write strobes
  wire wr_ctrl    = wr_hit(bus_wr, wb_adr_i, wb_sel_i, `PWC_ADR_CTRL);
  wire wr_opt     = wr_hit(bus_wr, wb_adr_i, wb_sel_i, `PWC_ADR_OPTION);
  wire wr_edge    = wr_hit(bus_wr, wb_adr_i, wb_sel_i, `PWC_ADR_EDGE);
  wire wr_outctl  = wr_hit(bus_wr, wb_adr_i, wb_sel_i, `PWC_ADR_OUTCTL);
  wire wr_extctl  = wr_hit(bus_wr, wb_adr_i, wb_sel_i, `PWC_ADR_EXTCTL);
  wire wr_irq_en  = wr_hit(bus_wr, wb_adr_i, wb_sel_i, `PWC_ADR_IRQ_EN);
  wire wr_irq_clr = wr_hit(bus_wr, wb_adr_i, wb_sel_i, `PWC_ADR_IRQ_CLR);
  wire wr_bitclr  = wr_hit(bus_wr, wb_adr_i, wb_sel_i, `PWC_ADR_BITCLR);

  // valid edges, seen only while the counter runs
  wire [3:0] edge_det;
  assign edge_det[0] = running && edge_hit(edge_sel_q[`PWC_EDGE_CH0], pin_sync_q[0], pin_last_q[0]);
  assign edge_det[1] = running && edge_hit(edge_sel_q[`PWC_EDGE_CH1], pin_sync_q[1], pin_last_q[1]);
  assign edge_det[2] = running && edge_hit(edge_sel_q[`PWC_EDGE_CH2], pin_sync_q[2], pin_last_q[2]);
  assign edge_det[3] = running && edge_hit(edge_sel_q[`PWC_EDGE_CH3], pin_sync_q[3], pin_last_q[3]);

  wire any_edge = |edge_det;
  wire at_max   = (cnt_q == `PWC_CNT_MAX);
  // a tick while the counter sits at FFFF is the wrap; its pulse follows one clock later
  wire wrap_now = running && count_tick_i && at_max;

  // synchroniser: nothing but pin_sync_q reads the first flop
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= `PWC_CH_ZERO;
      pin_sync_q <= `PWC_CH_ZERO;
      pin_last_q <= `PWC_CH_ZERO;
    end else begin
      pin_meta_q <= capture_input_i;
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
    end
  end

  // output and external input control never reach the counter path
  always @* begin
    cnt_d = cnt_q;
    if (!running) begin
      cnt_d = `PWC_CNT_ZERO;
    end else if (is_pulse && any_edge) begin
      // a tick in the capture clock is dropped, so captures count ticks since the edge
      cnt_d = `PWC_CNT_ZERO;
    end else if (count_tick_i) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= `PWC_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // overflow request pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      ovf_irq_q <= 1'b0;
    end else begin
      ovf_irq_q <= wrap_now;
    end
  end

  // capture request pulses, one per channel
  always @(posedge clk_i) begin
    if (rst_i) begin
      cap_irq_q <= `PWC_CH_ZERO;
    end else begin
      cap_irq_q <= edge_det;
    end
  end

  // software may preload a capture register only while the counter is stopped
  always @(posedge clk_i) begin
    for (j = 0; j < `PWC_NUM_CH; j = j + 1) begin
      if (rst_i) begin
        cap_q[j] <= `PWC_CNT_ZERO;
      end else if (edge_det[j]) begin
        cap_q[j] <= cnt_q;
      end else if (wr_hit(bus_wr, wb_adr_i, wb_sel_i, cap_adr(j[1:0])) && !running) begin
        cap_q[j] <= wb_dat_i[WIDTH-1:0];
      end
    end
  end

  // shared sticky flag: a wrap in the clearing cycle wins
  wire ovf_clr = (wr_opt && !wb_dat_i[`PWC_OPT_OVF]) ||
                 (wr_bitclr && wb_dat_i[`PWC_OPT_OVF]);

  always @* begin
    ovf_d = ovf_q;
    if (wrap_now) begin
      ovf_d = 1'b1;
    end else if (ovf_clr) begin
      ovf_d = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  // status bits: a new event beats a clear written in the same clock
  wire [4:0] events  = {wrap_now, edge_det};
  wire [4:0] clr_msk = wr_irq_clr ? wb_dat_i[`PWC_IRQ_OVF:0] : `PWC_IRQ_ZERO;

  always @* begin
    stat_d = events | (stat_q & ~clr_msk);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= `PWC_IRQ_ZERO;
    end else begin
      stat_q <= stat_d;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `PWC_REG8_ZERO;
    end else if (wr_ctrl) begin
      ctrl_q <= wb_dat_i[`PWC_BYTE_MSB:0];
    end
  end

  // unused channels are expected to be set to no edge by software
  always @(posedge clk_i) begin
    if (rst_i) begin
      edge_sel_q <= `PWC_REG8_ZERO;
    end else if (wr_edge) begin
      edge_sel_q <= wb_dat_i[`PWC_BYTE_MSB:0];
    end
  end

  // stored for software only; capture modes drive no output pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      outctl_q <= `PWC_REG8_ZERO;
    end else if (wr_outctl) begin
      outctl_q <= wb_dat_i[`PWC_BYTE_MSB:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      extctl_q <= `PWC_REG8_ZERO;
    end else if (wr_extctl) begin
      extctl_q <= wb_dat_i[`PWC_BYTE_MSB:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_q <= `PWC_IRQ_ZERO;
    end else if (wr_irq_en) begin
      irq_en_q <= wb_dat_i[`PWC_IRQ_OVF:0];
    end
  end

  // read multiplexer; write-only and unmapped addresses read as zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = `PWC_ZERO32;
    case (wb_adr_i)
      `PWC_ADR_CTRL:     rd_mux[`PWC_BYTE_MSB:0] = ctrl_q;
      `PWC_ADR_OPTION:   rd_mux[`PWC_OPT_OVF] = ovf_q;
      `PWC_ADR_EDGE:     rd_mux[`PWC_BYTE_MSB:0] = edge_sel_q;
      `PWC_ADR_OUTCTL:   rd_mux[`PWC_BYTE_MSB:0] = outctl_q;
      `PWC_ADR_EXTCTL:   rd_mux[`PWC_BYTE_MSB:0] = extctl_q;
      `PWC_ADR_COUNT:    rd_mux[WIDTH-1:0] = cnt_q;
      `PWC_ADR_CAP0:     rd_mux[WIDTH-1:0] = cap_q[0];
      `PWC_ADR_CAP1:     rd_mux[WIDTH-1:0] = cap_q[1];
      `PWC_ADR_CAP2:     rd_mux[WIDTH-1:0] = cap_q[2];
      `PWC_ADR_CAP3:     rd_mux[WIDTH-1:0] = cap_q[3];
      `PWC_ADR_IRQ_STAT: rd_mux[`PWC_IRQ_OVF:0] = stat_q;
      `PWC_ADR_IRQ_EN:   rd_mux[`PWC_IRQ_OVF:0] = irq_en_q;
      default:           rd_mux = `PWC_ZERO32;
    endcase
  end

  // single-wait-state slave: every address acks, one clock after the request is taken
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // read data stands with ack only, zero otherwise, so stale values never leak
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `PWC_ZERO32;
    end else begin
      wb_dat_o <= bus_rd ? rd_mux : `PWC_ZERO32;
    end
  end

  // one level line for all enabled status bits together
  wire [4:0] irq_pend = stat_q & irq_en_q;

  assign capture_irq_o  = cap_irq_q;
  assign overflow_irq_o = ovf_irq_q;
  assign irq_o          = |irq_pend;

endmodule // pwc_timer

// ---- pwc_defs.vh ----
// constants for the pulse width capture timer: register offsets, fields, modes
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
`ifndef PWC_DEFS_VH
`define PWC_DEFS_VH

`define PWC_ADR_CTRL     6'h00
`define PWC_ADR_OPTION   6'h04
`define PWC_ADR_EDGE     6'h08
`define PWC_ADR_OUTCTL   6'h0C
`define PWC_ADR_EXTCTL   6'h10
`define PWC_ADR_COUNT    6'h14
`define PWC_ADR_CAP0     6'h18
`define PWC_ADR_CAP1     6'h1C
`define PWC_ADR_CAP2     6'h20
`define PWC_ADR_CAP3     6'h24
`define PWC_ADR_IRQ_STAT 6'h28
`define PWC_ADR_IRQ_EN   6'h2C
`define PWC_ADR_IRQ_CLR  6'h30
`define PWC_ADR_BITCLR   6'h34

`define PWC_CTRL_CE      7
`define PWC_MODE_LO      0
`define PWC_MODE_HI      2
`define PWC_MODE_FREE    3'h5
`define PWC_MODE_PULSE   3'h6
`define PWC_OPT_OVF      0

`define PWC_EDGE_NONE    2'h0
`define PWC_EDGE_RISE    2'h1
`define PWC_EDGE_FALL    2'h2
`define PWC_EDGE_BOTH    2'h3

`define PWC_IRQ_OVF      4
`define PWC_CNT_ZERO     16'h0000
`define PWC_CNT_MAX      16'hFFFF
`define PWC_ZERO32       32'h00000000
`define PWC_BYTE_MSB     7
`define PWC_REG8_ZERO    8'h00
`define PWC_CH_ZERO      4'h0
`define PWC_IRQ_ZERO     5'h00
`define PWC_NUM_CH       4
`define PWC_EDGE_CH0     1:0
`define PWC_EDGE_CH1     3:2
`define PWC_EDGE_CH2     5:4
`define PWC_EDGE_CH3     7:6

`endif

// ---- pwc_timer_props.sv ----
// port checker for pwc_timer: bus handshake, read data, pulse outputs
// attached by bind below; sees the top module's ports only
module pwc_timer_props (
  input logic        clk_i,
  input logic        rst_i,
  input logic        count_tick_i,
  input logic [3:0]  capture_input_i,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o,
  input logic [31:0] wb_dat_o,
  input logic [3:0]  capture_irq_o,
  input logic        overflow_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_take: assert property (p_take) else $error("request not acknowledged");
  property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_cause: assert property (p_cause) else $error("ack without request");
  property p_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_once: assert property (p_once) else $error("ack longer than one cycle");
  property p_idle; !wb_ack_o |-> wb_dat_o == 32'h00000000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside ack");
  property p_upper; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_ovf_gap; overflow_irq_o |=> !overflow_irq_o [*8]; endproperty
  a_ovf_gap: assert property (p_ovf_gap) else $error("overflow pulse repeated");
  property p_ovf_tick; overflow_irq_o |-> $past(count_tick_i); endproperty
  a_ovf_tick: assert property (p_ovf_tick) else $error("overflow without tick");
  // allows two cycles of slack past the synchroniser delay, none short of it
  property p_cap; capture_irq_o[0] |-> $past(capture_input_i[0], 3) != $past(capture_input_i[0], 6); endproperty
  a_cap: assert property (p_cap) else $error("capture without pin edge");
endmodule // pwc_timer_props
bind pwc_timer pwc_timer_props chk_u (.clk_i(clk_i), .rst_i(rst_i), .count_tick_i(count_tick_i),
  .capture_input_i(capture_input_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .capture_irq_o(capture_irq_o),
  .overflow_irq_o(overflow_irq_o));

// ---- pwc_pins_model.sv ----
// capture pin sources: each request bit toggles its pin once
// pins hold their level between edges, as a pulse source does
module pwc_pins_model (
  input  logic       clk_i,
  input  logic [3:0] fire_i,
  output logic [3:0] pin_o = 4'h0
);
  always @(posedge clk_i) pin_o <= pin_o ^ fire_i;
endmodule // pwc_pins_model

// ---- pulse_width_capture_timer_tb.sv ----
// bench for pwc_timer: pulse, overflow and free-running captures
// drives wishbone and the count tick; pins come from pwc_pins_model
`include "pwc_defs.vh"
module pulse_width_capture_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, rst_i = 1, tick = 0, cyc = 0, stb = 0, we = 0, ack, ovf, irq;
  logic [5:0]  adr = 6'h00;
  logic [3:0]  fire = 4'h0, pins, cap;
  logic [31:0] wdat = 32'h00000000, rdat, q;
  int          failures = 0, num_checks = 0;
  always #5 clk_i = ~clk_i;
  pwc_pins_model pins_u (.clk_i(clk_i), .fire_i(fire), .pin_o(pins));
  pwc_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .count_tick_i(tick), .capture_input_i(pins),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .capture_irq_o(cap),
    .overflow_irq_o(ovf), .irq_o(irq));
  task final_report;
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'h0;
    if (ack !== 1'b1) begin failures++; final_report; end
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h00000000);
    chk(n, e, q);
  endtask
  // exactly k count ticks, one per clock
  task ticks(input int k);
    repeat (k) begin @(posedge clk_i); tick <= 1'b1; end
    @(posedge clk_i);
    tick <= 1'b0;
  endtask
  task capture(input logic [3:0] m);
    int n;
    n = 0;
    @(posedge clk_i);
    fire <= m;
    @(posedge clk_i);
    fire <= 4'h0;
    while ((cap & m) !== m && n < 20) begin @(posedge clk_i); n++; end
    if ((cap & m) !== m) begin failures++; final_report; end
  endtask
  task sc_pulse;
    bus(1'b1, `PWC_ADR_IRQ_EN, 32'h0000001F);
    bus(1'b1, `PWC_ADR_EDGE, 32'h00000001);
    bus(1'b1, `PWC_ADR_CTRL, 32'h00000086);
    ticks(7);
    capture(4'h1);
    rd(`PWC_ADR_CAP0, 32'h00000007, "cap0");
    rd(`PWC_ADR_COUNT, 32'h00000000, "count");
    chk("irq", 32'h00000001, {31'h0, irq});
    bus(1'b1, `PWC_ADR_IRQ_CLR, 32'h0000001F);
    chk("irq", 32'h00000000, {31'h0, irq});
    ticks(5);
    rd(`PWC_ADR_COUNT, 32'h00000005, "count");
  endtask
  task sc_overflow;
    ticks(65531);
    @(posedge clk_i);
    chk("ovf_irq", 32'h00000001, {31'h0, ovf});
    rd(`PWC_ADR_COUNT, 32'h00000000, "count");
    rd(`PWC_ADR_OPTION, 32'h00000001, "ovf");
    chk("irq", 32'h00000001, {31'h0, irq});
    bus(1'b1, `PWC_ADR_OPTION, 32'h00000001);
    rd(`PWC_ADR_OPTION, 32'h00000001, "ovf");
    bus(1'b1, `PWC_ADR_BITCLR, 32'h00000000);
    rd(`PWC_ADR_OPTION, 32'h00000001, "ovf");
    bus(1'b1, `PWC_ADR_OPTION, 32'h00000000);
    rd(`PWC_ADR_OPTION, 32'h00000000, "ovf");
  endtask
  task sc_free;
    bus(1'b1, `PWC_ADR_CTRL, 32'h00000006);
    rd(`PWC_ADR_COUNT, 32'h00000000, "count");
    bus(1'b1, `PWC_ADR_EDGE, 32'h00000003);
    bus(1'b1, `PWC_ADR_CTRL, 32'h00000085);
    ticks(3);
    capture(4'h1);
    rd(`PWC_ADR_CAP0, 32'h00000003, "cap0");
    rd(`PWC_ADR_COUNT, 32'h00000003, "count");
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`PWC_ADR_COUNT, 32'h00000000, "count");
    sc_pulse;
    sc_overflow;
    sc_free;
    final_report;
  end
endmodule // pulse_width_capture_timer_tb
